// ===== rtl/usb_node_dma.sv
/*
  Function address matching and automatic DMA control for a USB node.
  Assumes an APB master on clk, a serial engine reporting per-packet
  events on clk for the selected endpoint, and a DMA controller that
  returns a one-cycle done pulse per DMA cycle.
*/
`timescale 1ns/1ps
`default_nettype none
`include "usb_node_dma_regs.svh"

// What this block does
// - Match tokens against stored 7-bit address
// - Address enable clear ignores all tokens
// - Default respond bit matches default address
// - Endpoint select codes map endpoints one-six
// - Mode zero requests on transfer completion
// - Mode one requests on FIFO warning
// - Auto enable also enables selected endpoint
// - Auto mode ends on any of event flags zero-three
// - Initial toggle write loads next toggle
// - Toggle mismatch stops unless ignored
// - Disable ends after current DMA cycle
// - Flags zero-three raise interrupt while set
// - Halt flag set after cleanup reaches idle
// - Event flags clear on zero write
// - Error flag on bad packet or mismatch
// - Auto error handling delays error flag
// - Count flag when packet count zero
// - Short packet flag on short receive
// - Ready flag after flush, clears on end
// - Next toggle flips per packet, overrides
// - Mask gates events onto alternate event
// - Count decrements, no underflow, write wins
// - Default respond clears after endpoint-0 IN
module usb_node_dma
  import usb_node_dma_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire token_t token,
  output logic tokenMatch,
  input wire logic ep0InSent,
  input wire logic defaultAddrRespondIn,
  input wire logic defaultAddrWrite,
  input wire pkt_evt_t pktEvt,
  input wire logic fifoWarn,
  input wire logic idleBetweenTxn,
  output logic flushReq,
  input wire logic flushDone,
  input wire logic softHalt,
  output logic dmaReq,
  input wire logic dmaDone,
  output logic [5:0] endpointEnable,
  output logic [5:0] toggleOverride,
  output logic autoActive,
  output logic nextToggle,
  output logic eventIrq,
  output logic dmaAltEvent
);

  logic [7:0] funcAddr_r; // Enable plus address
  logic [7:0] dmaCtrl_r; // Control register
  logic [3:0] evFlag_r; // Halt, error, count and size flags
  logic nextToggle_r; // Expected toggle of the next packet
  logic [7:0] dmaMask_r; // Event mask
  logic [7:0] pktCount_r; // Packets left
  logic auto_err_handling_r; // Automatic error handling
  logic [6:0] errPreset_r; // Consecutive error preset
  logic [6:0] errCount_r; // Consecutive error counter
  logic defaultAddrRespond_r; // Respond to default address
  logic dmaBusy_r; // DMA cycle outstanding
  logic softHaltSeen_r; // Halt requested during run
  logic cond_r; // Previous request condition
  auto_state_t autoState_r; // Sequencer state
  logic wrEn; // APB write access
  logic rdEn; // APB read access
  logic [2:0] dmaEndpointSelect; // Selected endpoint code
  logic selValid; // Code not reserved
  logic selIsTx; // Even endpoint code transmits
  logic pktDone; // A packet ended on the endpoint
  logic pktGood; // Packet ended without error
  logic badPkt; // Receive error or missing ack
  logic tglMiss; // Toggle mismatch
  logic errEvent; // Error to record
  logic cond; // Request condition
  logic stopEvent; // Any of the halt, error, count or size flags set

  // Decode an endpoint code into a one-hot endpoint vector
  function automatic logic [5:0] ep_onehot(input logic [2:0] code);
    logic [5:0] v;
    v = 6'h00;
    if (code < 3'h6)
    begin
      v[code] = 1'b1;
    end
    return v;
  endfunction

  // Register write of a flag: zero clears, one leaves it
  function automatic logic flag_w(input logic cur, input logic wbit);
    return cur & wbit;
  endfunction

  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Endpoint selection and packet classification
  assign dmaEndpointSelect = dmaCtrl_r[2:0];
  assign selValid = (dmaEndpointSelect < 3'h6);
  assign selIsTx = ~dmaEndpointSelect[0];
  assign pktDone = selIsTx ? pktEvt.txDone : pktEvt.rxLast;
  assign badPkt = selIsTx ? (pktEvt.txDone & ~pktEvt.ackSeen)
                          : (pktEvt.rxLast & pktEvt.rxError);
  // Compared against the toggle before it flips this cycle
  assign tglMiss = pktDone & ~selIsTx & ~pktEvt.rxError &
                   ~dmaCtrl_r[`CTL_IGN_RX_TGL] &
                   (pktEvt.rxToggle != nextToggle_r);
  assign pktGood = pktDone & ~badPkt & ~tglMiss;
  // Error flag waits for the counter when auto handling is on
  assign errEvent = autoActive & (badPkt | tglMiss) &
                    (~auto_err_handling_r || errCount_r == 7'h00);
  assign stopEvent = |evFlag_r;

  // Address match for incoming tokens
  always_comb
  begin
    tokenMatch = 1'b0;
    if (token.valid && funcAddr_r[`FA_EN_BIT])
    begin
      tokenMatch = (token.addr == funcAddr_r[6:0]);
      if (defaultAddrRespond_r && token.endp == 4'h0 &&
          token.addr == `DEFAULT_ADDR)
      begin
        tokenMatch = 1'b1;
      end
    end
  end

  // Function address register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      funcAddr_r <= `REG_RESET;
    else if (wrEn && paddr == `OFF_FUNC_ADDR)
      funcAddr_r <= pwdata[7:0];
  end

  // Default respond bit mirrored from endpoint 0 control
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      defaultAddrRespond_r <= 1'b0;
    else if (defaultAddrWrite)
      defaultAddrRespond_r <= defaultAddrRespondIn;
    else if (ep0InSent)
      defaultAddrRespond_r <= 1'b0;
  end

  // Control register; auto bit dropped when the run ends
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dmaCtrl_r <= `REG_RESET;
    else if (wrEn && paddr == `OFF_DMA_CTRL)
      dmaCtrl_r <= pwdata[7:0];
    else if (autoState_r == AUTO_STOP && !dmaBusy_r)
      dmaCtrl_r[`CTL_AUTO_EN] <= 1'b0;
  end

  // Mask and error control registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dmaMask_r <= `REG_RESET;
      auto_err_handling_r <= 1'b0;
      errPreset_r <= 7'h00;
    end
    else if (wrEn)
    begin
      if (paddr == `OFF_DMA_MASK)
        dmaMask_r <= pwdata[7:0];
      // Error control is locked while auto mode runs
      if (paddr == `OFF_ERR_CTRL && !autoActive)
      begin
        auto_err_handling_r <= pwdata[7];
        errPreset_r <= pwdata[6:0];
      end
    end
  end

  // Consecutive error counter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      errCount_r <= 7'h00;
    else if (!autoActive || pktGood)
      errCount_r <= errPreset_r;
    else if (auto_err_handling_r && (badPkt | tglMiss) &&
             errCount_r != 7'h00)
      errCount_r <= errCount_r - 7'h01;
  end

  // Packet count: write wins, decrement stops at zero
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pktCount_r <= `REG_RESET;
    else if (wrEn && paddr == `OFF_PKT_COUNT)
      pktCount_r <= pwdata[7:0];
    else if (autoActive && pktGood && pktCount_r != 8'h00)
      pktCount_r <= pktCount_r - 8'h01;
  end

  // Event flags: hardware set wins over a zero write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      evFlag_r <= 4'h0;
    else
    begin
      if (wrEn && paddr == `OFF_DMA_EVENT)
      begin
        evFlag_r[`EV_HALT] <= flag_w(evFlag_r[`EV_HALT], pwdata[0]);
        evFlag_r[`EV_ERR] <= flag_w(evFlag_r[`EV_ERR], pwdata[1]);
        evFlag_r[`EV_CNT] <= flag_w(evFlag_r[`EV_CNT], pwdata[2]);
        evFlag_r[`EV_SIZE] <= flag_w(evFlag_r[`EV_SIZE], pwdata[3]);
      end
      if (autoState_r == AUTO_STOP && softHaltSeen_r && !dmaBusy_r)
        evFlag_r[`EV_HALT] <= 1'b1;
      if (errEvent)
        evFlag_r[`EV_ERR] <= 1'b1;
      if (autoActive && pktGood && pktCount_r == 8'h00)
        evFlag_r[`EV_CNT] <= 1'b1;
      if (autoActive && pktGood && !selIsTx && pktEvt.shortPkt)
        evFlag_r[`EV_SIZE] <= 1'b1;
    end
  end

  // Software halt remembered until the engine is idle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      softHaltSeen_r <= 1'b0;
    else if (autoState_r == AUTO_IDLE)
      softHaltSeen_r <= 1'b0;
    else if (softHalt)
      softHaltSeen_r <= 1'b1;
  end

  // Next toggle: control write wins over packet flip
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      nextToggle_r <= 1'b0;
    else if (wrEn && paddr == `OFF_DMA_CTRL)
      nextToggle_r <= pwdata[`CTL_INIT_TGL];
    else if (pktDone && selValid && !badPkt)
      nextToggle_r <= ~nextToggle_r;
  end

  // Automatic DMA sequencer
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      autoState_r <= AUTO_IDLE;
    else
    begin
      unique case (autoState_r)
        AUTO_IDLE:
        begin
          // Start relies on software clearing flags and enable first
          if (dmaCtrl_r[`CTL_AUTO_EN] && selValid && !stopEvent)
            autoState_r <= AUTO_START;
        end
        AUTO_START:
        begin
          // Wait for the bus to go quiet and the FIFO to flush
          if (!dmaCtrl_r[`CTL_AUTO_EN])
            autoState_r <= AUTO_IDLE;
          else if (flushDone)
            autoState_r <= AUTO_RUN;
        end
        AUTO_RUN:
        begin
          if (stopEvent || softHalt || !dmaCtrl_r[`CTL_AUTO_EN])
            autoState_r <= AUTO_STOP;
        end
        AUTO_STOP:
        begin
          // Let the outstanding DMA cycle finish
          if (!dmaBusy_r)
            autoState_r <= AUTO_IDLE;
        end
      endcase
    end
  end
  assign autoActive = (autoState_r == AUTO_RUN);
  assign flushReq = (autoState_r == AUTO_START) & idleBetweenTxn;

  // Request condition edge detector
  always_comb
  begin
    if (dmaCtrl_r[`CTL_REQ_MODE])
      cond = fifoWarn;
    else
      cond = pktDone;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cond_r <= 1'b0;
    else
      cond_r <= cond;
  end

  // DMA request held until the controller completes the cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      dmaBusy_r <= 1'b0;
    else if (dmaBusy_r && dmaDone)
      dmaBusy_r <= 1'b0;
    else if (!dmaBusy_r && selValid && cond && !cond_r &&
             (dmaCtrl_r[`CTL_DMA_EN] || autoActive))
      dmaBusy_r <= 1'b1;
  end
  assign dmaReq = dmaBusy_r;

  // Endpoint enable and toggle override toward the serial engine
  assign endpointEnable = (dmaCtrl_r[`CTL_AUTO_EN] || autoActive) ?
                          ep_onehot(dmaEndpointSelect) : 6'h00;
  assign toggleOverride = (autoActive && selIsTx) ?
                          ep_onehot(dmaEndpointSelect) : 6'h00;
  assign nextToggle = nextToggle_r;

  // Interrupt and alternate event outputs
  assign eventIrq = stopEvent;
  assign dmaAltEvent = |({autoActive, evFlag_r} & dmaMask_r[4:0]);

  // APB read mux
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        `OFF_FUNC_ADDR: prdata <= {24'h000000, funcAddr_r};
        `OFF_DMA_CTRL: prdata <= {24'h000000, dmaCtrl_r};
        `OFF_DMA_EVENT: prdata <= {26'h0, nextToggle_r, autoActive, evFlag_r};
        `OFF_DMA_MASK: prdata <= {24'h000000, dmaMask_r};
        `OFF_PKT_COUNT: prdata <= {24'h000000, pktCount_r};
        `OFF_ERR_CTRL: prdata <= {24'h000000, auto_err_handling_r,
                          autoActive ? errCount_r : errPreset_r};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // usb_node_dma
`default_nettype wire

// ===== rtl/usb_node_dma_regs.svh
/*
  Register offsets, field positions, reset values and widths for the
  function address and automatic DMA block.
  Assumes inclusion by bare name from the design module.
*/
`ifndef USB_NODE_DMA_REGS_SVH
`define USB_NODE_DMA_REGS_SVH

// Byte offsets on the APB port
`define OFF_FUNC_ADDR 8'h00
`define OFF_DMA_CTRL 8'h04
`define OFF_DMA_EVENT 8'h08
`define OFF_DMA_MASK 8'h0C
`define OFF_PKT_COUNT 8'h10
`define OFF_ERR_CTRL 8'h14

// Function address fields
`define FA_EN_BIT 7
`define DEFAULT_ADDR 7'h00

// DMA control fields
`define CTL_DMA_EN 7
`define CTL_IGN_RX_TGL 6
`define CTL_INIT_TGL 5
`define CTL_AUTO_EN 4
`define CTL_REQ_MODE 3

// DMA event fields
`define EV_HALT 0
`define EV_ERR 1
`define EV_CNT 2
`define EV_SIZE 3
`define EV_READY 4
`define EV_NEXT_TOGGLE 5

// Reset value of all registers
`define REG_RESET 8'h00

`endif

// ===== rtl/usb_node_dma_pkg.sv
/*
  Types shared by the function address and automatic DMA block.
  Assumes the register header is on the include path.
*/
package usb_node_dma_pkg;

  // Automatic DMA sequencer states
  typedef enum logic [1:0] {
    AUTO_IDLE,
    AUTO_START,
    AUTO_RUN,
    AUTO_STOP
  } auto_state_t;

  // Per-packet event report from the serial engine
  typedef struct packed {
    logic txDone;
    logic rxLast;
    logic ackSeen;
    logic rxError;
    logic rxToggle;
    logic shortPkt;
  } pkt_evt_t;

  // Token seen by the address matcher
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [3:0] endp;
  } token_t;

endpackage

// ===== verif/usb_node_dma_monitor.sv
/*
  Port checker for the address match and automatic DMA block.
  Assumes a bind to usb_node_dma with one clock and async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_node_dma_monitor
  import usb_node_dma_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire token_t token,
  input wire logic tokenMatch,
  input wire logic idleBetweenTxn,
  input wire logic flushReq,
  input wire logic flushDone,
  input wire logic dmaReq,
  input wire logic dmaDone,
  input wire logic [5:0] endpointEnable,
  input wire logic [5:0] toggleOverride,
  input wire logic autoActive,
  input wire logic nextToggle,
  input wire logic eventIrq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // A match needs a live token
  AST_MATCH: assert property (tokenMatch |-> token.valid)
    else $error("match without token");
  // Outputs quiet right after reset
  AST_RESET: assert property ($rose(resetn) |-> !dmaReq && !eventIrq)
    else $error("output active after reset");
  // At most one endpoint served
  AST_ONEHOT: assert property ($onehot0(endpointEnable))
    else $error("several endpoints enabled");
  // Request holds until the DMA cycle ends
  AST_REQ: assert property (dmaReq && !dmaDone |=> dmaReq)
    else $error("request dropped early");
  // Flush only while starting between transactions
  AST_FLUSH: assert property (flushReq |-> idleBetweenTxn && !autoActive)
    else $error("flush out of place");
  // Ready follows a finished flush
  AST_READY: assert property ($rose(autoActive) |-> $past(flushDone))
    else $error("ready without flush");
  // Toggle override only in automatic mode
  AST_TGL: assert property (|toggleOverride |-> autoActive)
    else $error("override outside auto mode");
  // Control write loads the next toggle
  AST_NEXT_TOGGLE: assert property (psel && penable && pwrite && pready &&
    paddr == 8'h04 |=> nextToggle == $past(pwdata[5]))
    else $error("next toggle not loaded");
endmodule // usb_node_dma_monitor
`default_nettype wire

// ===== verif/usb_node_dma_partner.sv
/*
  DMA controller and flush responder beside the block.
  Assumes the request is held until the done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_node_dma_partner
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic dmaReq,
  input wire logic flushReq,
  output logic dmaDone,
  output logic flushDone
);
  logic [2:0] waitCnt; // Cycles spent on this DMA cycle
  // Answers a request promptly or after five cycles
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      waitCnt <= 3'h0;
      dmaDone <= 1'b0;
    end
    else
    begin
      dmaDone <= 1'b0;
      waitCnt <= 3'h0;
      if (dmaReq && !dmaDone)
      begin
        waitCnt <= waitCnt + 3'h1;
        dmaDone <= waitCnt >= (slow ? 3'h4 : 3'h0);
      end
    end
  // Flush completes one cycle after it is asked for
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
      flushDone <= 1'b0;
    else
      flushDone <= flushReq && !flushDone;
endmodule // usb_node_dma_partner
`default_nettype wire

// ===== verif/tb_usb_node_dma.sv
/*
  Self-checking bench: APB master, packet stimulus, queued checks.
  Assumes the partner model answers DMA and flush requests.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_usb_node_dma
  import usb_node_dma_pkg::*;
;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata;
  token_t token; // Token under test
  pkt_evt_t pktEvt; // Packet end report
  logic tokenMatch, ep0InSent, defaultAddrRespondIn, defaultAddrWrite;
  logic fifoWarn, idleBetweenTxn, flushReq, flushDone, softHalt, slow;
  logic dmaReq, dmaDone, autoActive, nextToggle, eventIrq, dmaAltEvent;
  logic reqSeen;
  logic [5:0] endpointEnable, toggleOverride;
  logic [7:0] rdQ[$], mkQ[$], tokQ[$]; // Expected results
  int errorCnt, comparisons, i, reqPend;
  int seed = 32'hF6F7A807;
  usb_node_dma u_usb_node_dma (.clk, .resetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .prdata, .pready, .pslverr, .token, .tokenMatch,
    .ep0InSent, .defaultAddrRespondIn, .defaultAddrWrite, .pktEvt,
    .fifoWarn, .idleBetweenTxn, .flushReq, .flushDone, .softHalt, .dmaReq,
    .dmaDone, .endpointEnable, .toggleOverride, .autoActive, .nextToggle,
    .eventIrq, .dmaAltEvent);
  usb_node_dma_partner u_usb_node_dma_partner (.clk, .resetn, .slow,
    .dmaReq, .flushReq, .dmaDone, .flushDone);
  // Verdict and end of run
  task automatic closeOut();
    $display("Counts: %0d compares, %0d errors", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bounded wait: 0 request served, 1 auto on, 2 auto off
  task automatic waitFor(input int k);
    int n;
    n = 0;
    while (n < 80 && (k == 0 ? (reqPend > 0 || dmaReq !== 1'b0)
                             : autoActive !== k[0]))
    begin
      n++;
      @(posedge clk);
    end
    if (n == 80)
    begin
      errorCnt++;
      closeOut();
    end
  endtask
  // One APB transfer, held until pready, then an idle cycle
  task automatic apb(input logic [7:0] ad, input logic w,
                     input logic [7:0] d);
    int n;
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1; n++)
    begin
      if (n == 50)
      begin
        errorCnt++;
        closeOut();
      end
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e, m);
    rdQ.push_back(e & m);
    mkQ.push_back(m);
    apb(ad, 1'b0, 8'h00);
  endtask
  task automatic tok(input logic [6:0] ad, input logic [3:0] e,
                     input logic x);
    tokQ.push_back({7'h0, x});
    token <= {1'b1, ad, e};
    @(posedge clk);
    token <= '0;
    @(posedge clk);
  endtask
  task automatic pkt(input pkt_evt_t p);
    pktEvt <= p;
    @(posedge clk);
    pktEvt <= '0;
    @(posedge clk);
  endtask
  // Watcher: compares each result with the oldest note
  always @(posedge clk)
  begin
    reqSeen <= dmaReq;
    if (psel && penable && !pwrite && pready && rdQ.size() > 0)
      check(prdata[7:0] & mkQ.pop_front(), rdQ.pop_front());
    if (psel && penable && pready)
      check({7'h0, pslverr}, 8'h00);
    if (token.valid && tokQ.size() > 0)
      check({7'h0, tokenMatch}, tokQ.pop_front());
    if (dmaReq && !reqSeen && reqPend >= 0)
    begin
      check({7'h0, reqPend > 0}, 8'h01);
      reqPend--;
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    {resetn, psel, penable, pwrite, ep0InSent, fifoWarn, softHalt} = '0;
    {defaultAddrRespondIn, defaultAddrWrite, slow, paddr, pwdata} = '0;
    {token, pktEvt} = '0;
    idleBetweenTxn = 1'b1;
    reqPend = -1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 5; i++)
      rd(i == 4 ? 8'h18 : 8'(i * 4), 8'h00, 8'hFF);
    a = 8'($random(seed));
    apb(8'h0C, 1'b1, a);
    rd(8'h0C, a, 8'h1F);
    $display("Test registers done");
    a = 8'($random(seed)) | 8'h01;
    apb(8'h00, 1'b1, {1'b1, a[6:0]});
    tok(a[6:0], 4'h1, 1'b1);
    tok(a[6:0] ^ 7'h02, 4'h1, 1'b0);
    apb(8'h00, 1'b1, {1'b0, a[6:0]});
    tok(a[6:0], 4'h1, 1'b0);
    apb(8'h00, 1'b1, {1'b1, a[6:0]});
    {defaultAddrRespondIn, defaultAddrWrite} <= 2'h3;
    @(posedge clk);
    defaultAddrWrite <= 1'b0;
    tok(7'h00, 4'h0, 1'b1);
    ep0InSent <= 1'b1;
    @(posedge clk);
    ep0InSent <= 1'b0;
    tok(7'h00, 4'h0, 1'b0);
    $display("Test address done");
    apb(8'h04, 1'b1, 8'h20);
    rd(8'h08, 8'h20, 8'hFF);
    reqPend = 0;
    for (i = 0; i < 12; i++)
    begin
      slow <= i[0];
      apb(8'h04, 1'b1, {1'b1, 3'h0, i >= 6, 3'(i % 6)});
      if (i < 6)
        pkt(i[0] ? 6'h20 : 6'h10);
      reqPend++;
      if (i < 6)
        pkt(i[0] ? 6'h10 : 6'h20);
      else
        fifoWarn <= 1'b1;
      waitFor(0);
      fifoWarn <= 1'b0;
    end
    reqPend = -1;
    $display("Test requests done");
    apb(8'h10, 1'b1, 8'h05);
    apb(8'h0C, 1'b1, 8'h02);
    apb(8'h04, 1'b1, 8'h10);
    waitFor(1);
    check({2'h0, endpointEnable}, 8'h01);
    check({2'h0, toggleOverride}, 8'h01);
    rd(8'h08, 8'h10, 8'h3F);
    pkt(6'h28);
    rd(8'h08, 8'h30, 8'h3F);
    pkt(6'h20);
    waitFor(2);
    check({6'h0, eventIrq, dmaAltEvent}, 8'h03);
    rd(8'h08, 8'h02, 8'h1F);
    apb(8'h08, 1'b1, 8'hFD);
    rd(8'h08, 8'h00, 8'h1F);
    apb(8'h04, 1'b1, 8'h10);
    waitFor(1);
    softHalt <= 1'b1;
    @(posedge clk);
    softHalt <= 1'b0;
    waitFor(2);
    rd(8'h08, 8'h01, 8'h1F);
    apb(8'h08, 1'b1, 8'h00);
    apb(8'h04, 1'b1, 8'h11);
    waitFor(1);
    pkt(6'h12);
    waitFor(2);
    rd(8'h08, 8'h02, 8'h1F);
    apb(8'h08, 1'b1, 8'h00);
    apb(8'h04, 1'b1, 8'h51);
    waitFor(1);
    pkt(6'h12);
    check({7'h0, autoActive}, 8'h01);
    pkt(6'h13);
    waitFor(2);
    rd(8'h08, 8'h08, 8'h1F);
    slow <= 1'b0;
    apb(8'h04, 1'b1, 8'h16);
    check({2'h0, endpointEnable}, 8'h00);
    apb(8'h04, 1'b1, 8'h00);
    apb(8'h08, 1'b1, 8'h00);
    apb(8'h10, 1'b1, 8'h01);
    apb(8'h14, 1'b1, 8'h81);
    apb(8'h04, 1'b1, 8'h10);
    waitFor(1);
    pkt(6'h20);
    check({7'h0, autoActive}, 8'h01);
    rd(8'h14, 8'h80, 8'hFF);
    pkt(6'h28);
    rd(8'h10, 8'h00, 8'hFF);
    pkt(6'h28);
    waitFor(2);
    rd(8'h08, 8'h04, 8'h1F);
    apb(8'h08, 1'b1, 8'h00);
    apb(8'h04, 1'b1, 8'h10);
    waitFor(1);
    pkt(6'h20);
    pkt(6'h20);
    waitFor(2);
    rd(8'h08, 8'h02, 8'h1F);
    $display("Test automatic mode done");
    closeOut();
  end
endmodule // tb_usb_node_dma
bind usb_node_dma usb_node_dma_monitor u_usb_node_dma_monitor (.clk,
  .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .token,
  .tokenMatch, .idleBetweenTxn, .flushReq, .flushDone, .dmaReq, .dmaDone,
  .endpointEnable, .toggleOverride, .autoActive, .nextToggle, .eventIrq);
`default_nettype wire
